// ### rtl/cdg_top.sv
// Complementary dead-band generator with APB register slave
// Function
// - Two drives derived from one selected source
// - Clock select: system clock or 16 MHz oscillator
// - Three-bit select picks one of six sources
// - Both drives deasserted right after enabling
// - Output enable clear releases the pin
// - Enabled pin shows override or waveform
// - Module disabled: enables and levels ignored
// - Per-output polarity, set means active-high
// - Polarity never applies to override levels
// - Two six-bit counters, rising and falling; the code shares one six-bit count for both edges
// - Count clock periods from zero to setting
// - Rising edge turns B off at once
// - Rising count done turns A on
// - Rising setting spans zero to full range
// - Zero setting inserts no dead time
// - Counting starts from the source edge
// - Too-short pulse leaves output unasserted
// - Falling edge: A off, count, B on
// - Shutdown bit forces override levels
// - Shutdown inputs level-sensitive, block leaving shutdown
// - Overrides hold until first rising edge after
//
// Design decisions made here: the APB register port and the address map.
`default_nettype none
module cdg_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [cdg_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pulse_source_1,
  input wire logic pulse_source_2,
  input wire logic pulse_source_3,
  input wire logic pulse_source_4,
  input wire logic oscillator_source,
  input wire logic logic_cell_source,
  input wire logic shutdown_in_0,
  input wire logic shutdown_in_1,
  input wire logic internal_fast_oscillator,
  output logic drive_a_out,
  output logic drive_a_oe_n,
  output logic drive_b_out,
  output logic drive_b_oe_n
);
  cdg_pkg::cdg_state_type s;
  cdg_pkg::cdg_state_type next_s;
  logic [cdg_pkg::SYNC_W-1:0] raw_in;
  logic [cdg_pkg::SYNC_W-1:0] synced;
  logic source_now;
  logic [1:0] sd_in;
  logic sd_level;
  logic tick;
  logic rise;
  logic fall;
  logic setup_phase;
  logic write_take;
  logic mapped;

  // ******************************************************************
  // Input synchronisation
  // ******************************************************************
  // Sources may be asynchronous; costs up to one clock of dead-band jitter
  assign raw_in = {internal_fast_oscillator, shutdown_in_1, shutdown_in_0, logic_cell_source,
                   oscillator_source, pulse_source_4, pulse_source_3, pulse_source_2,
                   pulse_source_1};

  cdg_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(raw_in),
    .sync_out(synced)
  );

  // Source mux; unused codes fall back to the first pulse source
  always_comb begin
    case (s.input_source_select)
      cdg_pkg::SEL_PULSE_1: source_now = synced[cdg_pkg::SEL_PULSE_1];
      cdg_pkg::SEL_PULSE_2: source_now = synced[cdg_pkg::SEL_PULSE_2];
      cdg_pkg::SEL_PULSE_3: source_now = synced[cdg_pkg::SEL_PULSE_3];
      cdg_pkg::SEL_PULSE_4: source_now = synced[cdg_pkg::SEL_PULSE_4];
      cdg_pkg::SEL_OSCILLATOR: source_now = synced[cdg_pkg::SEL_OSCILLATOR];
      cdg_pkg::SEL_LOGIC_CELL: source_now = synced[cdg_pkg::SEL_LOGIC_CELL];
      default: source_now = synced[cdg_pkg::SEL_PULSE_1];
    endcase
  end

  // Edge and shutdown detection
  assign sd_in = synced[cdg_pkg::LANE_SD_LSB +: cdg_pkg::SD_W];
  assign sd_level = |(sd_in & s.shutdown_select);
  assign rise = s.module_enable && source_now && !s.source_prev;
  assign fall = s.module_enable && !source_now && s.source_prev;
  // One count per oscillator rising edge, else one per system clock
  assign tick = s.count_clock_select ?
                (synced[cdg_pkg::LANE_FAST_OSC] && !s.osc_prev) : 1'b1;

  // ******************************************************************
  // APB decode
  // ******************************************************************
  assign setup_phase = psel && !penable;
  assign write_take = psel && penable && pwrite;
  assign mapped = (paddr == cdg_pkg::OUTPUT_CONTROL_REG_OFFSET) ||
                  (paddr == cdg_pkg::INPUT_SELECT_REG_OFFSET) ||
                  (paddr == cdg_pkg::RISING_DEADTIME_OFFSET) ||
                  (paddr == cdg_pkg::FALLING_DEADTIME_OFFSET) ||
                  (paddr == cdg_pkg::SHUTDOWN_REG_OFFSET) ||
                  (paddr == cdg_pkg::STATUS_REG_OFFSET);
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ******************************************************************
  // Next-state logic
  // ******************************************************************
  always_comb begin
    next_s = s;
    next_s.source_prev = source_now;
    next_s.osc_prev = synced[cdg_pkg::LANE_FAST_OSC];

    // Register writes; unmapped writes are dropped
    if (write_take) begin
      case (paddr)
        cdg_pkg::OUTPUT_CONTROL_REG_OFFSET: begin
          next_s.module_enable = pwdata[cdg_pkg::MODULE_ENABLE_BIT];
          next_s.drive_b_output_enable = pwdata[cdg_pkg::DRIVE_B_OE_BIT];
          next_s.drive_a_output_enable = pwdata[cdg_pkg::DRIVE_A_OE_BIT];
          next_s.drive_b_polarity = pwdata[cdg_pkg::DRIVE_B_POL_BIT];
          next_s.drive_a_polarity = pwdata[cdg_pkg::DRIVE_A_POL_BIT];
          next_s.count_clock_select = pwdata[cdg_pkg::CLOCK_SELECT_BIT];
        end
        cdg_pkg::INPUT_SELECT_REG_OFFSET: begin
          next_s.input_source_select = pwdata[cdg_pkg::SELECT_W-1:0];
        end
        cdg_pkg::RISING_DEADTIME_OFFSET: begin
          next_s.rising_deadtime_count = pwdata[cdg_pkg::DEADTIME_W-1:0];
        end
        cdg_pkg::FALLING_DEADTIME_OFFSET: begin
          next_s.falling_deadtime_count = pwdata[cdg_pkg::DEADTIME_W-1:0];
        end
        cdg_pkg::SHUTDOWN_REG_OFFSET: begin
          next_s.shutdown_active = pwdata[cdg_pkg::SHUTDOWN_ACTIVE_BIT];
          next_s.auto_restart = pwdata[cdg_pkg::AUTO_RESTART_BIT];
          next_s.override_b = pwdata[cdg_pkg::OVERRIDE_B_BIT];
          next_s.override_a = pwdata[cdg_pkg::OVERRIDE_A_BIT];
          next_s.shutdown_select = pwdata[cdg_pkg::SHUTDOWN_SEL_LSB +: cdg_pkg::SD_W];
        end
        default: begin
          next_s.prdata = s.prdata;
        end
      endcase
    end

    // Auto-restart clears shutdown once the selected inputs are all low
    if (s.auto_restart && s.shutdown_active && !sd_level) begin
      next_s.shutdown_active = 1'b0;
    end
    // Hardware set wins over any clear in the same cycle
    if (sd_level) begin
      next_s.shutdown_active = 1'b1;
    end

    // Overrides latch in shutdown, release on first rise after it ends
    if (next_s.shutdown_active) begin
      next_s.hold_override = 1'b1;
    end else if (!s.shutdown_active && rise) begin
      next_s.hold_override = 1'b0;
    end

    // Dead-band sequencer, always timed from the source edge
    if (!s.module_enable) begin
      next_s.phase = cdg_pkg::PH_IDLE;
      next_s.raw_a = 1'b0;
      next_s.raw_b = 1'b0;
      next_s.count = cdg_pkg::DEADTIME_RESET;
    end else if (rise) begin
      next_s.raw_b = 1'b0;
      next_s.count = cdg_pkg::DEADTIME_RESET;
      next_s.raw_a = (s.rising_deadtime_count == cdg_pkg::DEADTIME_RESET);
      next_s.phase = next_s.raw_a ? cdg_pkg::PH_HIGH : cdg_pkg::PH_RISE;
    end else if (fall) begin
      next_s.raw_a = 1'b0;
      next_s.count = cdg_pkg::DEADTIME_RESET;
      next_s.raw_b = (s.falling_deadtime_count == cdg_pkg::DEADTIME_RESET);
      next_s.phase = next_s.raw_b ? cdg_pkg::PH_LOW : cdg_pkg::PH_FALL;
    end else begin
      case (s.phase)
        cdg_pkg::PH_RISE: begin
          if (s.count == s.rising_deadtime_count) begin
            next_s.raw_a = 1'b1;
            next_s.phase = cdg_pkg::PH_HIGH;
          end else if (tick) begin
            next_s.count = s.count + 6'h01;
          end
        end
        cdg_pkg::PH_FALL: begin
          if (s.count == s.falling_deadtime_count) begin
            next_s.raw_b = 1'b1;
            next_s.phase = cdg_pkg::PH_LOW;
          end else if (tick) begin
            next_s.count = s.count + 6'h01;
          end
        end
        cdg_pkg::PH_IDLE: begin
          next_s.phase = cdg_pkg::PH_IDLE;
        end
        cdg_pkg::PH_HIGH: begin
          next_s.phase = cdg_pkg::PH_HIGH;
        end
        cdg_pkg::PH_LOW: begin
          next_s.phase = cdg_pkg::PH_LOW;
        end
        default: begin
          next_s.phase = cdg_pkg::PH_IDLE;
        end
      endcase
    end

    // Pin levels: override ignores polarity, waveform honours it
    if (!s.module_enable) begin
      next_s.drive_a_out = 1'b0;
      next_s.drive_b_out = 1'b0;
      next_s.drive_a_oe_n = 1'b1;
      next_s.drive_b_oe_n = 1'b1;
    end else begin
      next_s.drive_a_out = next_s.hold_override ? s.override_a :
                           (next_s.raw_a ~^ s.drive_a_polarity);
      next_s.drive_b_out = next_s.hold_override ? s.override_b :
                           (next_s.raw_b ~^ s.drive_b_polarity);
      next_s.drive_a_oe_n = !s.drive_a_output_enable;
      next_s.drive_b_oe_n = !s.drive_b_output_enable;
    end

    // Read data captured in setup so the access phase can finish at once
    if (setup_phase) begin
      next_s.prdata = '0;
      case (paddr)
        cdg_pkg::OUTPUT_CONTROL_REG_OFFSET: begin
          next_s.prdata[cdg_pkg::MODULE_ENABLE_BIT] = s.module_enable;
          next_s.prdata[cdg_pkg::DRIVE_B_OE_BIT] = s.drive_b_output_enable;
          next_s.prdata[cdg_pkg::DRIVE_A_OE_BIT] = s.drive_a_output_enable;
          next_s.prdata[cdg_pkg::DRIVE_B_POL_BIT] = s.drive_b_polarity;
          next_s.prdata[cdg_pkg::DRIVE_A_POL_BIT] = s.drive_a_polarity;
          next_s.prdata[cdg_pkg::CLOCK_SELECT_BIT] = s.count_clock_select;
        end
        cdg_pkg::INPUT_SELECT_REG_OFFSET: begin
          next_s.prdata[cdg_pkg::SELECT_W-1:0] = s.input_source_select;
        end
        cdg_pkg::RISING_DEADTIME_OFFSET: begin
          next_s.prdata[cdg_pkg::DEADTIME_W-1:0] = s.rising_deadtime_count;
        end
        cdg_pkg::FALLING_DEADTIME_OFFSET: begin
          next_s.prdata[cdg_pkg::DEADTIME_W-1:0] = s.falling_deadtime_count;
        end
        cdg_pkg::SHUTDOWN_REG_OFFSET: begin
          next_s.prdata[cdg_pkg::SHUTDOWN_ACTIVE_BIT] = s.shutdown_active;
          next_s.prdata[cdg_pkg::AUTO_RESTART_BIT] = s.auto_restart;
          next_s.prdata[cdg_pkg::OVERRIDE_B_BIT] = s.override_b;
          next_s.prdata[cdg_pkg::OVERRIDE_A_BIT] = s.override_a;
          next_s.prdata[cdg_pkg::SHUTDOWN_SEL_LSB +: cdg_pkg::SD_W] = s.shutdown_select;
        end
        cdg_pkg::STATUS_REG_OFFSET: begin
          next_s.prdata[cdg_pkg::STAT_RAW_A_BIT] = s.raw_a;
          next_s.prdata[cdg_pkg::STAT_RAW_B_BIT] = s.raw_b;
          next_s.prdata[cdg_pkg::STAT_HOLD_BIT] = s.hold_override;
          next_s.prdata[cdg_pkg::STAT_SOURCE_BIT] = source_now;
          next_s.prdata[cdg_pkg::STAT_SD_LSB +: cdg_pkg::SD_W] = sd_in;
        end
        default: begin
          next_s.prdata = '0;
        end
      endcase
    end
  end

  // State register; outputs released and drives low in reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.drive_a_oe_n <= 1'b1;
      s.drive_b_oe_n <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign drive_a_out = s.drive_a_out;
  assign drive_b_out = s.drive_b_out;
  assign drive_a_oe_n = s.drive_a_oe_n;
  assign drive_b_oe_n = s.drive_b_oe_n;

  // ******************************************************************
  // Assertions
  // ******************************************************************
  property p_rise_b_off;
    @(posedge pclk) disable iff (!presetn) rise |=> !s.raw_b;
  endproperty
  a_rise_b_off: assert property (p_rise_b_off) else $error("B not off after rise");

  property p_fall_a_off;
    @(posedge pclk) disable iff (!presetn) fall |=> !s.raw_a;
  endproperty
  a_fall_a_off: assert property (p_fall_a_off) else $error("A not off after fall");

  property p_zero_rise;
    @(posedge pclk) disable iff (!presetn)
      rise && (s.rising_deadtime_count == 6'h00) |=> s.raw_a;
  endproperty
  a_zero_rise: assert property (p_zero_rise) else $error("Zero dead time delayed A");

  sequence s_rise_two;
    rise && !s.count_clock_select && (s.rising_deadtime_count == 6'h02);
  endsequence
  sequence s_steady_high;
    source_now && s.module_enable && !write_take;
  endsequence
  // Only judged when the source stays high and nothing is rewritten mid-count
  property p_rise_count;
    @(posedge pclk) disable iff (!presetn)
      s_rise_two ##1 s_steady_high [*3]
      |-> !$past(s.raw_a, 2) && !$past(s.raw_a) && !s.raw_a ##1 s.raw_a;
  endproperty
  a_rise_count: assert property (p_rise_count) else $error("Rising dead time wrong");

  property p_short_pulse;
    @(posedge pclk) disable iff (!presetn)
      (s.phase == cdg_pkg::PH_RISE) && fall |=> !s.raw_a ##1 !s.raw_a;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("Short pulse drove A");

  property p_disabled;
    @(posedge pclk) disable iff (!presetn)
      !s.module_enable |=> drive_a_oe_n && drive_b_oe_n && !s.raw_a && !s.raw_b;
  endproperty
  a_disabled: assert property (p_disabled) else $error("Disabled block drives pins");

  property p_oe_a;
    @(posedge pclk) disable iff (!presetn)
      s.module_enable && !s.drive_a_output_enable |=> drive_a_oe_n;
  endproperty
  a_oe_a: assert property (p_oe_a) else $error("Pin A driven while disabled");

  property p_override;
    @(posedge pclk) disable iff (!presetn)
      s.hold_override && $past(s.module_enable) |-> drive_a_out == $past(s.override_a);
  endproperty
  a_override: assert property (p_override) else $error("Override level wrong");

  property p_polarity;
    @(posedge pclk) disable iff (!presetn)
      !s.hold_override && $past(s.module_enable)
      |-> drive_b_out == (s.raw_b ~^ $past(s.drive_b_polarity));
  endproperty
  a_polarity: assert property (p_polarity) else $error("Polarity wrong on B");

  property p_sd_hold;
    @(posedge pclk) disable iff (!presetn) sd_level |=> s.shutdown_active && s.hold_override;
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("Shutdown input ignored");

  property p_hold_until_rise;
    @(posedge pclk) disable iff (!presetn)
      s.hold_override && !rise |=> s.hold_override;
  endproperty
  a_hold_until_rise: assert property (p_hold_until_rise) else $error("Override left early");
endmodule
`default_nettype wire

// ### rtl/cdg_pkg.sv
// Package of constants and types for the complementary dead-band generator
`default_nettype none
package cdg_pkg;
  // ********************************************************************
  // Register map
  // ********************************************************************
  localparam int ADDR_W = 12;
  localparam logic [11:0] OUTPUT_CONTROL_REG_OFFSET = 12'h000;
  localparam logic [11:0] INPUT_SELECT_REG_OFFSET = 12'h004;
  localparam logic [11:0] RISING_DEADTIME_OFFSET = 12'h008;
  localparam logic [11:0] FALLING_DEADTIME_OFFSET = 12'h00c;
  localparam logic [11:0] SHUTDOWN_REG_OFFSET = 12'h010;
  localparam logic [11:0] STATUS_REG_OFFSET = 12'h014;

  // Output control fields
  localparam int MODULE_ENABLE_BIT = 7;
  localparam int DRIVE_B_OE_BIT = 6;
  localparam int DRIVE_A_OE_BIT = 5;
  localparam int DRIVE_B_POL_BIT = 4;
  localparam int DRIVE_A_POL_BIT = 3;
  localparam int CLOCK_SELECT_BIT = 0;

  // Shutdown register fields
  localparam int SHUTDOWN_ACTIVE_BIT = 7;
  localparam int AUTO_RESTART_BIT = 6;
  localparam int OVERRIDE_B_BIT = 5;
  localparam int OVERRIDE_A_BIT = 4;
  localparam int SHUTDOWN_SEL_LSB = 0;

  // Status register fields
  localparam int STAT_RAW_A_BIT = 0;
  localparam int STAT_RAW_B_BIT = 1;
  localparam int STAT_HOLD_BIT = 2;
  localparam int STAT_SOURCE_BIT = 3;
  localparam int STAT_SD_LSB = 4;

  // Widths and reset values
  localparam int DEADTIME_W = 6;
  localparam int SELECT_W = 3;
  localparam int SD_W = 2;
  localparam logic [5:0] DEADTIME_RESET = 6'h00;
  localparam logic [2:0] SELECT_RESET = 3'h0;

  // Input source codes and synchroniser lanes
  localparam logic [2:0] SEL_PULSE_1 = 3'h0;
  localparam logic [2:0] SEL_PULSE_2 = 3'h1;
  localparam logic [2:0] SEL_PULSE_3 = 3'h2;
  localparam logic [2:0] SEL_PULSE_4 = 3'h3;
  localparam logic [2:0] SEL_OSCILLATOR = 3'h4;
  localparam logic [2:0] SEL_LOGIC_CELL = 3'h5;
  localparam int SYNC_W = 9;
  localparam int LANE_SD_LSB = 6;
  localparam int LANE_FAST_OSC = 8;

  typedef enum logic [2:0] {PH_IDLE, PH_RISE, PH_HIGH, PH_FALL, PH_LOW} cdg_phase_type;

  typedef struct packed {
    logic [SYNC_W-1:0] stage1;
    logic [SYNC_W-1:0] stage2;
    logic [SYNC_W-1:0] stage3;
    logic [SYNC_W-1:0] level;
  } cdg_sync_type;

  typedef struct packed {
    logic module_enable;
    logic drive_b_output_enable;
    logic drive_a_output_enable;
    logic drive_b_polarity;
    logic drive_a_polarity;
    logic count_clock_select;
    logic [2:0] input_source_select;
    logic [5:0] rising_deadtime_count;
    logic [5:0] falling_deadtime_count;
    logic shutdown_active;
    logic auto_restart;
    logic override_b;
    logic override_a;
    logic [1:0] shutdown_select;
    cdg_phase_type phase;
    logic [5:0] count;
    logic source_prev;
    logic osc_prev;
    logic raw_a;
    logic raw_b;
    logic hold_override;
    logic drive_a_out;
    logic drive_b_out;
    logic drive_a_oe_n;
    logic drive_b_oe_n;
    logic [31:0] prdata;
  } cdg_state_type;
endpackage
`default_nettype wire

// ### rtl/cdg_sync.sv
// Three-stage synchroniser for the asynchronous source, shutdown and oscillator inputs
`default_nettype none
module cdg_sync (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [cdg_pkg::SYNC_W-1:0] async_in,
  output logic [cdg_pkg::SYNC_W-1:0] sync_out
);
  cdg_pkg::cdg_sync_type s;
  cdg_pkg::cdg_sync_type next_s;

  // ******************************************************************
  // Shift chain and agreement filter
  // ******************************************************************
  // Stage one feeds stage two only; level follows once stages two and three agree
  always_comb begin
    next_s = s;
    next_s.stage1 = async_in;
    next_s.stage2 = s.stage1;
    next_s.stage3 = s.stage2;
    next_s.level = (s.stage2 & s.stage3) | (s.level & (s.stage2 ^ s.stage3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.level;
endmodule
`default_nettype wire

// ### tb/cdg_switch_model.sv
// Behavioural model of the power-switch drivers hanging on the two output pins
`default_nettype none
module cdg_switch_model (
  input wire logic drive_a_out,
  input wire logic drive_a_oe_n,
  input wire logic drive_b_out,
  input wire logic drive_b_oe_n,
  output logic pin_a,
  output logic pin_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // Gate inputs carry pull-downs, so a released pin reads low, never a stale level
  assign pin_a = drive_a_oe_n ? 1'b0 : drive_a_out;
  assign pin_b = drive_b_oe_n ? 1'b0 : drive_b_out;
endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the complementary dead-band generator
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic osc = 1'b0;
  logic [1:0] oc = 2'h0;
  logic [1:0] sd = 2'h0;
  logic [5:0] src = 6'h00;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] seed = 32'h0000dff4;
  logic [31:0] prdata, rd, r;
  logic pready, pslverr, er, a_out, a_oe_n, b_out, b_oe_n, pin_a, pin_b, seen;
  int num_errors = 0;
  int checks_done = 0;
  int d, i, m, idx;
  int nl[6] = '{0, 1, 63, 2, 0, 0};

  // Clock and a roughly 16 MHz oscillator stepped on the clock edge
  always #5 pclk = ~pclk;
  always @(posedge pclk) begin
    oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
    if (oc == 2'h2) begin
      osc <= ~osc;
    end
  end

  cdg_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_source_1(src[0]), .pulse_source_2(src[1]),
    .pulse_source_3(src[2]), .pulse_source_4(src[3]), .oscillator_source(src[4]),
    .logic_cell_source(src[5]), .shutdown_in_0(sd[0]), .shutdown_in_1(sd[1]),
    .internal_fast_oscillator(osc), .drive_a_out(a_out), .drive_a_oe_n(a_oe_n),
    .drive_b_out(b_out), .drive_b_oe_n(b_oe_n));
  cdg_switch_model model (.drive_a_out(a_out), .drive_a_oe_n(a_oe_n),
    .drive_b_out(b_out), .drive_b_oe_n(b_oe_n), .pin_a(pin_a), .pin_b(pin_b));

  // ******************************************************************
  // Helpers
  // ******************************************************************
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Designer counts N+1 periods, zero means no gap at all
  function int exp_dead(input int v);
    return (v == 0) ? 0 : v + 1;
  endfunction

  function logic sig(input int s);
    case (s)
      0: return pin_a;
      1: return pin_b;
      2: return a_oe_n;
      default: return b_oe_n;
    endcase
  endfunction

  task wrap_up;
    $display("Errors %0d, checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      chk(1'b0, 1'b1);
      wrap_up();
    end
  endtask

  task put(input logic [5:0] v);
    @(posedge pclk);
    src <= v;
  endtask

  // Bounded wait for a pin or enable level, checked afterwards
  task lvl(input int s, input logic v);
    int k;
    #1;
    for (k = 0; k < 40 && sig(s) !== v; k++) begin
      @(posedge pclk);
      #1;
    end
    chk(sig(s), v);
    if (sig(s) !== v) wrap_up();
  endtask

  // Cycles from the off-going pin falling to the on-going pin rising
  task meas(input logic v, output int dd);
    int k;
    put({5'h00, v});
    for (k = 0; k < 40 && sig(v ? 1 : 0) !== 1'b0; k++) begin
      @(posedge pclk);
      #1;
    end
    for (dd = 0; dd < 2000 && sig(v ? 0 : 1) !== 1'b1; dd++) begin
      @(posedge pclk);
      #1;
    end
    if (k >= 40 || dd >= 2000) begin
      chk(1'b0, 1'b1);
      wrap_up();
    end
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b1, 12'h018, rnd());
    apb(1'b0, 12'h018, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    r = rnd();
    apb(1'b1, cdg_pkg::RISING_DEADTIME_OFFSET, r);
    apb(1'b0, cdg_pkg::RISING_DEADTIME_OFFSET, 32'h0);
    chk(rd, r & 32'h3f);
    // Enables set while the module is off must not reach the pins
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'h78);
    repeat (8) @(posedge pclk);
    chk({a_oe_n, b_oe_n}, 2'h3);
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'hf8);
    lvl(2, 1'b0);
    chk({a_out, b_out}, 2'h0);
    apb(1'b1, cdg_pkg::RISING_DEADTIME_OFFSET, 32'h0);
    // Every select code, with the other sources toggling at random
    for (i = 0; i < 8; i++) begin
      idx = (i > 5) ? 0 : i;
      apb(1'b1, cdg_pkg::INPUT_SELECT_REG_OFFSET, 32'(i));
      r = rnd();
      put(r[5:0] | (6'h01 << idx));
      lvl(0, 1'b1);
      lvl(1, 1'b0);
      put(r[13:8] & ~(6'h01 << idx));
      lvl(1, 1'b1);
      lvl(0, 1'b0);
    end
    put(6'h00);
    for (i = 4; i < 6; i++) begin
      r = rnd();
      nl[i] = int'(r[5:0]);
    end
    // Dead-time lengths including zero and the top value
    for (i = 0; i < 6; i++) begin
      r = rnd();
      m = int'(r[5:0]);
      apb(1'b1, cdg_pkg::RISING_DEADTIME_OFFSET, 32'(nl[i]));
      apb(1'b1, cdg_pkg::FALLING_DEADTIME_OFFSET, 32'(m));
      meas(1'b1, d);
      chk(d, exp_dead(nl[i]));
      meas(1'b0, d);
      chk(d, exp_dead(m));
    end
    // Pulse shorter than the rising gap never turns drive A on
    apb(1'b1, cdg_pkg::RISING_DEADTIME_OFFSET, 32'h14);
    apb(1'b1, cdg_pkg::FALLING_DEADTIME_OFFSET, 32'h2);
    put(6'h01);
    seen = 1'b0;
    for (i = 0; i < 40; i++) begin
      @(posedge pclk);
      if (i == 8) src <= 6'h00;
      #1;
      seen = seen | pin_a;
    end
    chk(seen, 1'b0);
    lvl(1, 1'b1);
    // Oscillator ticks stretch the same setting about sixfold
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'hf9);
    apb(1'b1, cdg_pkg::RISING_DEADTIME_OFFSET, 32'h4);
    meas(1'b1, d);
    chk(d >= 20 && d <= 40, 1'b1);
    meas(1'b0, d);
    chk(d >= 6 && d <= 16, 1'b1);
    // Active-low outputs, then overrides that ignore polarity
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'he0);
    lvl(0, 1'b1);
    lvl(1, 1'b0);
    apb(1'b1, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'ha1);
    lvl(0, 1'b0);
    lvl(1, 1'b1);
    @(posedge pclk);
    sd <= 2'h1;
    repeat (8) @(posedge pclk);
    apb(1'b1, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h21);
    apb(1'b0, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h0);
    chk(rd[7], 1'b1);
    sd <= 2'h0;
    repeat (8) @(posedge pclk);
    apb(1'b1, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h21);
    apb(1'b0, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h0);
    chk(rd[7], 1'b0);
    repeat (20) @(posedge pclk);
    #1;
    chk({pin_a, pin_b}, 2'h1);
    put(6'h01);
    repeat (12) @(posedge pclk);
    put(6'h00);
    lvl(0, 1'b1);
    lvl(1, 1'b0);
    // Auto-restart off the second shutdown input, then a rise releases the overrides
    apb(1'b1, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h62);
    sd <= 2'h2;
    lvl(0, 1'b0);
    apb(1'b0, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h0);
    chk(rd[7], 1'b1);
    apb(1'b0, cdg_pkg::STATUS_REG_OFFSET, 32'h0);
    chk(rd, 32'h26);
    sd <= 2'h0;
    repeat (8) @(posedge pclk);
    apb(1'b0, cdg_pkg::SHUTDOWN_REG_OFFSET, 32'h0);
    chk({rd[7], pin_a, pin_b}, 3'h1);
    put(6'h01);
    repeat (12) @(posedge pclk);
    put(6'h00);
    lvl(1, 1'b0);
    // Per-pin release, module release, then a fresh enable
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'hc0);
    lvl(2, 1'b1);
    lvl(3, 1'b0);
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'h78);
    lvl(3, 1'b1);
    apb(1'b1, cdg_pkg::OUTPUT_CONTROL_REG_OFFSET, 32'hf8);
    lvl(2, 1'b0);
    chk({a_out, b_out}, 2'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
